/* verilog/acu_consts.svh */
// Constants for the accumulator compare and add unit.
// Assumes inclusion by bare name from the unit and the checker.
`ifndef ACU_CONSTS_SVH
`define ACU_CONSTS_SVH

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define ACU_ACC_W 32
`define ACU_HALF_W 16
`define ACU_LEN_W 6
`define ACU_STACK_DEPTH 8
`define ACU_BCD_DIGITS 4

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define ACU_SIGN_BIT 31
`define ACU_MAG_MSB 30
`define ACU_EXP_MSB 30
`define ACU_EXP_LSB 23
`define ACU_MANT_MSB 22
`define ACU_EXP_ALL_ONES 8'h ff
`define ACU_ACC_RESET 32'h0000_0000
`define ACU_HALF_ZERO 16'h0000
`define ACU_BCD_MAX 5'h09
`define ACU_BCD_ADJ 5'h06
`define ACU_FIELD_FULL 6'h20

`endif

/* verilog/acu_pkg.sv */
// Types shared by the accumulator compare and add unit.
// Assumes the constants header sits beside this file.
package acu_pkg;

    // ----------------------------------------
    // Operation codes from the sequencer
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        acu_op_nop,
        acu_op_load,
        acu_op_cmp_double,
        acu_op_cmp_field,
        acu_op_cmp_stack,
        acu_op_cmp_real,
        acu_op_add
    } acu_op_t;

    // ----------------------------------------
    // Outcome of a compare
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        acu_rel_less,
        acu_rel_equal,
        acu_rel_greater
    } acu_rel_t;

endpackage

/* verilog/acu_unit.sv */
// Accumulator datapath slice: compares, single BCD add, accumulator stack.
// Assumes an instruction sequencer on the same clock that fetches operands and
// presents one operation per op_valid pulse.
//
// What this block does
// - Double compare checks full 32-bit accumulator against memory pair or constant.
// - Compare sets less, equal or greater flag from accumulator versus operand.
// - Each flag keeps its value until a later operation writes it.
// - Bit-field compare uses a run of zero to thirty-two bits.
// - Stack compare checks the accumulator against the first stack level.
// - Stack compare leaves accumulator alone and only updates relation flags.
// - Loading the accumulator pushes its old contents onto the stack.
// - Real compare treats both 32-bit values as real numbers numerically.
// - Real compare raises bad pointer flag when the pointer address is invalid.
// - Real operation raises invalid number flag on a non-real operand.
// - Single add adds memory BCD word into the accumulator.
// - Single add uses only the low 16 accumulator bits.
// - Add raises zero flag when the accumulator result is zero.
// - A 16-bit add carry out raises the 16-bit carry flag.
// - Add always clears the 32-bit carry flag; the single add never carries out of the full word.
// - Add raises negative flag when the accumulator result is negative.
// - BCD operation raises invalid number flag on any non-BCD digit in the low 16 bits of either value.
// - Negative means the accumulator result's top bit is one.
`timescale 1ns/1ps
`include "acu_consts.svh"

module acu_unit
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire acu_pkg::acu_op_t op_code,
    input wire logic [`ACU_ACC_W-1:0] operand,
    input wire logic [`ACU_LEN_W-1:0] field_len,
    input wire logic pointer_invalid,
    output logic op_done,
    output logic [`ACU_ACC_W-1:0] accumulator,
    output logic [`ACU_ACC_W-1:0] stack_top,
    output logic less_than_flag,
    output logic equal_flag,
    output logic greater_than_flag,
    output logic zero_result_flag,
    output logic carry16_flag,
    output logic carry32_flag,
    output logic negative_flag,
    output logic bad_pointer_flag,
    output logic invalid_number_flag
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic acu_pkg::acu_rel_t unsigned_rel(input logic [`ACU_ACC_W-1:0] a,
                                                       input logic [`ACU_ACC_W-1:0] b);
        if (a < b)
        begin
            return acu_pkg::acu_rel_less;
        end
        else if (a == b)
        begin
            return acu_pkg::acu_rel_equal;
        end
        return acu_pkg::acu_rel_greater;
    endfunction

    function automatic logic is_not_real(input logic [`ACU_ACC_W-1:0] v);
        return (v[`ACU_EXP_MSB:`ACU_EXP_LSB] == `ACU_EXP_ALL_ONES) && (v[`ACU_MANT_MSB:0] != '0);
    endfunction

    // Sign-magnitude ordering; both zeros compare equal
    function automatic acu_pkg::acu_rel_t real_rel(input logic [`ACU_ACC_W-1:0] a,
                                                   input logic [`ACU_ACC_W-1:0] b);
        logic a_neg;
        logic b_neg;
        acu_pkg::acu_rel_t mag;
        a_neg = a[`ACU_SIGN_BIT];
        b_neg = b[`ACU_SIGN_BIT];
        mag = unsigned_rel({1'b0, a[`ACU_MAG_MSB:0]}, {1'b0, b[`ACU_MAG_MSB:0]});
        if ((a[`ACU_MAG_MSB:0] == '0) && (b[`ACU_MAG_MSB:0] == '0))
        begin
            return acu_pkg::acu_rel_equal;
        end
        else if (a_neg != b_neg)
        begin
            return a_neg ? acu_pkg::acu_rel_less : acu_pkg::acu_rel_greater;
        end
        else if (!a_neg || (mag == acu_pkg::acu_rel_equal))
        begin
            return mag;
        end
        return (mag == acu_pkg::acu_rel_less) ? acu_pkg::acu_rel_greater : acu_pkg::acu_rel_less;
    endfunction

    function automatic logic has_bad_digit(input logic [`ACU_HALF_W-1:0] v);
        logic bad;
        bad = 1'b0;
        for (int d = 0; d < `ACU_BCD_DIGITS; d++)
        begin
            bad = bad | ({1'b0, v[d*4 +: 4]} > `ACU_BCD_MAX);
        end
        return bad;
    endfunction

    // ----------------------------------------
    // Accumulator stack storage
    // ----------------------------------------
    logic [`ACU_ACC_W-1:0] stack_mem [`ACU_STACK_DEPTH];

    // ----------------------------------------
    // Field mask for the bit-field compare
    // ----------------------------------------
    logic [`ACU_ACC_W:0] field_ones;
    logic [`ACU_ACC_W-1:0] field_value;
    logic [`ACU_LEN_W-1:0] field_len_clamped;

    // Lengths past the top are held to the full word rather than wrapping
    always_comb
    begin
        field_len_clamped = (field_len > `ACU_FIELD_FULL) ? `ACU_FIELD_FULL : field_len;
        field_ones = (33'h0_0000_0001 << field_len_clamped) - 33'h0_0000_0001;
        field_value = operand & field_ones[`ACU_ACC_W-1:0];
    end

    // ----------------------------------------
    // Decimal adder, one digit per stage
    // ----------------------------------------
    logic [`ACU_BCD_DIGITS:0] digit_carry;
    logic [`ACU_HALF_W-1:0] bcd_sum;
    logic bcd_bad;

    assign digit_carry[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < `ACU_BCD_DIGITS; g++)
        begin : gen_digit
            logic [4:0] raw;
            logic [4:0] fixed;
            always_comb
            begin
                raw = {1'b0, accumulator[g*4 +: 4]} + {1'b0, operand[g*4 +: 4]}
                      + {4'h0, digit_carry[g]};
                fixed = (raw > `ACU_BCD_MAX) ? (raw + `ACU_BCD_ADJ) : raw;
            end
            assign bcd_sum[g*4 +: 4] = fixed[3:0];
            assign digit_carry[g+1] = raw > `ACU_BCD_MAX;
        end
    endgenerate

    assign bcd_bad = has_bad_digit(accumulator[`ACU_HALF_W-1:0])
                     | has_bad_digit(operand[`ACU_HALF_W-1:0]);

    // ----------------------------------------
    // Next values per operation
    // ----------------------------------------
    logic [`ACU_ACC_W-1:0] next_accumulator;
    acu_pkg::acu_rel_t cmp_rel;
    logic cmp_write;
    logic real_skip;

    always_comb
    begin
        cmp_write = 1'b0;
        real_skip = 1'b0;
        cmp_rel = acu_pkg::acu_rel_equal;
        next_accumulator = accumulator;
        unique case (op_code)
            acu_pkg::acu_op_nop:
            begin
                next_accumulator = accumulator;
            end
            acu_pkg::acu_op_load:
            begin
                next_accumulator = operand;
            end
            acu_pkg::acu_op_cmp_double:
            begin
                cmp_write = 1'b1;
                cmp_rel = unsigned_rel(accumulator, operand);
            end
            acu_pkg::acu_op_cmp_field:
            begin
                cmp_write = 1'b1;
                cmp_rel = unsigned_rel(accumulator, field_value);
            end
            acu_pkg::acu_op_cmp_stack:
            begin
                cmp_write = 1'b1;
                cmp_rel = unsigned_rel(accumulator, stack_mem[0]);
            end
            acu_pkg::acu_op_cmp_real:
            begin
                // A bad address or a non-real value gives no meaningful order
                real_skip = pointer_invalid | is_not_real(accumulator) | is_not_real(operand);
                cmp_write = !real_skip;
                cmp_rel = real_rel(accumulator, operand);
            end
            acu_pkg::acu_op_add:
            begin
                next_accumulator = {accumulator[`ACU_ACC_W-1:`ACU_HALF_W], bcd_sum};
            end
            default:
            begin
                next_accumulator = accumulator;
            end
        endcase
    end

    // ----------------------------------------
    // Accumulator and stack
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            accumulator <= `ACU_ACC_RESET;
        end
        else if (op_valid)
        begin
            accumulator <= next_accumulator;
        end
    end

    generate
        for (g = 0; g < `ACU_STACK_DEPTH; g++)
        begin : gen_stack
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    stack_mem[g] <= `ACU_ACC_RESET;
                end
                else if (op_valid && (op_code == acu_pkg::acu_op_load))
                begin
                    // Deepest level falls off the bottom
                    stack_mem[g] <= (g == 0) ? accumulator : stack_mem[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    assign stack_top = stack_mem[0];

    // ----------------------------------------
    // Relation flags
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            less_than_flag <= 1'b0;
            equal_flag <= 1'b0;
            greater_than_flag <= 1'b0;
        end
        else if (op_valid && cmp_write)
        begin
            less_than_flag <= cmp_rel == acu_pkg::acu_rel_less;
            equal_flag <= cmp_rel == acu_pkg::acu_rel_equal;
            greater_than_flag <= cmp_rel == acu_pkg::acu_rel_greater;
        end
    end

    // ----------------------------------------
    // Real and BCD error flags
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bad_pointer_flag <= 1'b0;
            invalid_number_flag <= 1'b0;
        end
        else if (op_valid && (op_code == acu_pkg::acu_op_cmp_real))
        begin
            bad_pointer_flag <= pointer_invalid;
            invalid_number_flag <= is_not_real(accumulator) | is_not_real(operand);
        end
        else if (op_valid && (op_code == acu_pkg::acu_op_add))
        begin
            invalid_number_flag <= bcd_bad;
        end
    end

    // ----------------------------------------
    // Add result flags
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            zero_result_flag <= 1'b0;
            carry16_flag <= 1'b0;
            carry32_flag <= 1'b0;
            negative_flag <= 1'b0;
        end
        else if (op_valid && (op_code == acu_pkg::acu_op_add))
        begin
            zero_result_flag <= next_accumulator == `ACU_ACC_RESET;
            carry16_flag <= digit_carry[`ACU_BCD_DIGITS];
            // Only a 32-bit add can carry out of the full word; the single add never does
            carry32_flag <= 1'b0;
            negative_flag <= next_accumulator[`ACU_SIGN_BIT];
        end
    end

    // ----------------------------------------
    // Completion strobe
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_done <= 1'b0;
        end
        else
        begin
            op_done <= op_valid;
        end
    end

endmodule

/* tb/acu_unit_properties.sv */
// Checker for the accumulator unit, bound to every instance.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "acu_consts.svh"
module acu_unit_checker
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire acu_pkg::acu_op_t op_code,
    input wire logic [`ACU_ACC_W-1:0] operand,
    input wire logic [`ACU_LEN_W-1:0] field_len,
    input wire logic pointer_invalid,
    input wire logic op_done,
    input wire logic [`ACU_ACC_W-1:0] accumulator,
    input wire logic [`ACU_ACC_W-1:0] stack_top,
    input wire logic less_than_flag,
    input wire logic equal_flag,
    input wire logic greater_than_flag,
    input wire logic zero_result_flag,
    input wire logic carry16_flag,
    input wire logic carry32_flag,
    input wire logic negative_flag,
    input wire logic bad_pointer_flag,
    input wire logic invalid_number_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire [2:0] rel = {less_than_flag, equal_flag, greater_than_flag};
    wire [2:0] want = accumulator < operand ? 3'h4 : (accumulator == operand ? 3'h2 : 3'h1);
    wire [15:0] acc_hi = accumulator[31:16];
    wire [8:0] flags = {rel, zero_result_flag, carry16_flag, carry32_flag, negative_flag,
        bad_pointer_flag, invalid_number_flag};
    wire ld = op_valid && op_code == acu_pkg::acu_op_load;
    wire cd = op_valid && op_code == acu_pkg::acu_op_cmp_double;
    wire sk = op_valid && op_code == acu_pkg::acu_op_cmp_stack;
    wire rl = op_valid && op_code == acu_pkg::acu_op_cmp_real;
    wire ad = op_valid && op_code == acu_pkg::acu_op_add;
    wire cmp = cd || sk || (op_valid && op_code == acu_pkg::acu_op_cmp_field);

    chk_one_relation: assert property (cmp |=> $onehot(rel))
        else $error("relation flags not one-hot");
    chk_double_order: assert property (cd |=> rel == $past(want))
        else $error("double compare flag wrong");
    chk_stack_equal: assert property (sk && accumulator == stack_top |=> equal_flag)
        else $error("stack compare missed equal");
    chk_stack_keeps: assert property (sk |=> $stable(accumulator) && $stable(stack_top))
        else $error("stack compare changed data");
    chk_load_push: assert property (ld |=> stack_top == $past(accumulator) && accumulator == $past(operand))
        else $error("load did not push");
    chk_flags_hold: assert property (!op_valid |=> $stable(flags))
        else $error("flag moved without an operation");
    chk_real_pointer: assert property (rl |=> bad_pointer_flag == $past(pointer_invalid))
        else $error("bad pointer flag wrong");
    chk_real_nan: assert property (rl && operand[30:23] == 8'hff && operand[22:0] != 23'h00_0000
        |=> invalid_number_flag)
        else $error("non-real operand not flagged");
    chk_add_upper: assert property (ad |=> $stable(acc_hi))
        else $error("add touched upper half");
    chk_add_zero: assert property (ad |=> zero_result_flag == (accumulator == 32'h0000_0000))
        else $error("zero flag wrong");
    chk_add_sign: assert property (ad |=> negative_flag == accumulator[31])
        else $error("negative flag wrong");

    cover property (rl && pointer_invalid);
    cover property (ad ##1 carry16_flag);
    cover property (sk ##1 equal_flag);
endmodule

bind acu_unit acu_unit_checker chk (.*);

/* tb/acu_seq_model.sv */
// Sequencer model: presents one fetched operation per call.
// Assumes the unit samples its inputs on the rising clock edge.
`timescale 1ns/1ps
module acu_seq_model
(
    input wire logic clock,
    output logic op_valid = 1'h0,
    output acu_pkg::acu_op_t op_code = acu_pkg::acu_op_nop,
    output logic [31:0] operand = 32'h0000_0000,
    output logic [5:0] field_len = 6'h00,
    output logic pointer_invalid = 1'h0
);
    task automatic issue(input acu_pkg::acu_op_t op, input logic [31:0] opd, input logic [5:0] len, input logic ptr);
        @(posedge clock);
        #1;
        op_valid = 1'h1;
        op_code = op;
        operand = opd;
        field_len = len;
        pointer_invalid = ptr;
        @(posedge clock);
        #1;
        op_valid = 1'h0;
        // Released operand, length and pointer lines never keep the last word
        operand = ~opd;
        field_len = ~len;
        pointer_invalid = ~ptr;
    endtask
endmodule

/* tb/acu_unit_tb_top.sv */
// Self-checking bench for the accumulator unit with a reference model.
// Assumes the sequencer model and the bound checker are compiled first.
`timescale 1ns/1ps
module acu_unit_tb_top;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic op_valid, pointer_invalid, op_done, less_than_flag, equal_flag, greater_than_flag;
    logic zero_result_flag, carry16_flag, carry32_flag, negative_flag, bad_pointer_flag, invalid_number_flag;
    acu_pkg::acu_op_t op_code;
    logic [31:0] operand, accumulator, stack_top, a, m_acc;
    logic [5:0] field_len;
    logic [31:0] m_stk[$];
    logic [2:0] m_rel = 3'h0;
    logic m_zero = 1'h0, m_c16 = 1'h0, m_c32 = 1'h0, m_neg = 1'h0, m_bp = 1'h0, m_inv = 1'h0;
    int errors = 0;
    int total_checks = 0;
    logic [31:0] tv[12] = '{32'h40e0_0000, 32'h40c0_0000, 32'h8000_0000, 32'hbf80_0000, 32'h7f80_0000,
        32'h7fc0_0000, 32'h0000_9999, 32'h8000_1234, 32'h0000_0000, 32'h0000_4567, 32'h0000_0001, 32'h0000_5433};
    logic [5:0] lens[6] = '{6'h00, 6'h01, 6'h03, 6'h1f, 6'h20, 6'h28};

    always #20 clock = ~clock;
    acu_seq_model seq (.*);
    acu_unit uut (.*);

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic logic [2:0] rel_of(input logic [31:0] x, input logic [31:0] y);
        return x < y ? 3'h4 : (x == y ? 3'h2 : 3'h1);
    endfunction
    // Ordered key for reals; both zeros map to one key
    function automatic logic [31:0] rkey(input logic [31:0] x);
        return x[30:0] == 31'h0000_0000 ? 32'h8000_0000 : (x[31] ? ~x : {1'h1, x[30:0]});
    endfunction
    function automatic logic nan(input logic [31:0] x);
        return x[30:23] == 8'hff && x[22:0] != 23'h00_0000;
    endfunction
    function automatic logic [31:0] rbcd();
        logic [31:0] v;
        for (int i = 0; i < 8; i++) v[4*i+:4] = 4'($urandom_range(9, 0));
        return v;
    endfunction
    task automatic model(input acu_pkg::acu_op_t op, input logic [31:0] d, input logic [5:0] len, input logic p);
        logic [4:0] s;
        logic c;
        c = 1'h0;
        case (op)
            acu_pkg::acu_op_load:
            begin
                m_stk.push_front(m_acc);
                void'(m_stk.pop_back());
                m_acc = d;
            end
            acu_pkg::acu_op_cmp_double: m_rel = rel_of(m_acc, d);
            acu_pkg::acu_op_cmp_field: m_rel = rel_of(m_acc, len >= 6'h20 ? d : d & ((32'h1 << len) - 32'h1));
            acu_pkg::acu_op_cmp_stack: m_rel = rel_of(m_acc, m_stk[0]);
            acu_pkg::acu_op_cmp_real:
            begin
                m_bp = p;
                m_inv = nan(m_acc) || nan(d);
                if (!m_bp && !m_inv) m_rel = rel_of(rkey(m_acc), rkey(d));
            end
            acu_pkg::acu_op_add:
            begin
                m_inv = 1'h0;
                for (int i = 0; i < 4; i++)
                begin
                    m_inv |= m_acc[4*i+:4] > 4'h9 || d[4*i+:4] > 4'h9;
                    s = m_acc[4*i+:4] + d[4*i+:4] + c;
                    c = s > 5'h09;
                    m_acc[4*i+:4] = c ? s[3:0] + 4'h6 : s[3:0];
                end
                m_c16 = c;
                m_c32 = 1'h0;
                m_zero = m_acc == 32'h0000_0000;
                m_neg = m_acc[31];
            end
            default: ;
        endcase
    endtask

    // ----------------------------------------
    // Checking and stimulus
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic compare;
        check("accumulator", accumulator, m_acc);
        check("stack_top", stack_top, m_stk[0]);
        check("relation", {less_than_flag, equal_flag, greater_than_flag}, m_rel);
        check("zero", zero_result_flag, m_zero);
        check("carry16", carry16_flag, m_c16);
        check("carry32", carry32_flag, m_c32);
        check("negative", negative_flag, m_neg);
        check("bad_pointer", bad_pointer_flag, m_bp);
        check("invalid", invalid_number_flag, m_inv);
    endtask
    task automatic run(input acu_pkg::acu_op_t op, input logic [31:0] d, input logic [5:0] len, input logic p);
        int n;
        n = 0;
        seq.issue(op, d, len, p);
        model(op, d, len, p);
        while (op_done !== 1'h1 && n < 4)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check("op_done", op_done, 32'h0000_0001);
        compare;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #200_000;
        errors++;
        end_sim;
    end

    initial
    begin
        void'($urandom(32'h7bcc));
        m_acc = 32'h0000_0000;
        for (int i = 0; i < 8; i++) m_stk.push_back(32'h0000_0000);
        repeat (3) @(posedge clock);
        #1;
        rst_b = 1'h1;
        compare;
        $display("test reset done");
        for (int i = 0; i < 10; i++) run(acu_pkg::acu_op_load, $urandom, 6'h00, 1'h0);
        a = m_acc;
        for (int j = -1; j < 2; j++) run(acu_pkg::acu_op_cmp_double, a + j, 6'h00, 1'h0);
        run(acu_pkg::acu_op_load, 32'h0000_0007, 6'h00, 1'h0);
        for (int i = 0; i < 6; i++) run(acu_pkg::acu_op_cmp_field, 32'hffff_ffff, lens[i], 1'h0);
        for (int i = 0; i < 4; i++)
        begin
            run(acu_pkg::acu_op_load, tv[i / 2], 6'h00, 1'h0);
            run(acu_pkg::acu_op_cmp_stack, $urandom, 6'h00, 1'h0);
        end
        $display("test compare done");
        for (int i = 0; i < 8; i++)
        begin
            run(acu_pkg::acu_op_load, tv[i > 5 ? 0 : i], 6'h00, 1'h0);
            run(acu_pkg::acu_op_cmp_real, i == 6 ? tv[5] : tv[(i + 1) % 5], 6'h00, i == 7);
        end
        $display("test real done");
        for (int i = 6; i < 10; i++)
        begin
            run(acu_pkg::acu_op_load, tv[i], 6'h00, 1'h0);
            run(acu_pkg::acu_op_add, i == 8 ? 32'h0000_000a : tv[i + 2], 6'h00, 1'h0);
        end
        $display("test add done");
        for (int i = 0; i < 300; i++)
            run(acu_pkg::acu_op_t'(3'($urandom_range(7, 0))), rbcd(), 6'($urandom_range(40, 0)), 1'($urandom));
        $display("test random done");
        end_sim;
    end
endmodule
